//--- hdl/fpci_busy_timer.sv
// cycle timer for self-timed array operations
`timescale 1ns/1ps
`include "fpci_cfg.svh"
module fpci_busy_timer (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic ce_i,
	input  wire logic start_i,
	output logic      done_o
);
	import fpci_pkg::*;

	localparam logic [`FPCI_TMR_W-1:0] LAST =
		`FPCI_TMR_W'(`FPCI_OP_CYC - 1);

	logic [`FPCI_TMR_W-1:0] cnt_q;
	logic                   run_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q  <= '0;
			run_q  <= 1'b0;
			done_o <= 1'b0;
		end else if (ce_i) begin
			done_o <= 1'b0;
			if (start_i) begin
				cnt_q <= '0;
				run_q <= 1'b1;
			end else if (run_q) begin
				if (cnt_q == LAST) begin
					run_q  <= 1'b0;
					done_o <= 1'b1;
				end
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end
endmodule : fpci_busy_timer

//--- hdl/fpci_cfg.svh
// constants for the flash pin control interface
`ifndef FPCI_CFG_SVH
`define FPCI_CFG_SVH

// opcodes; bit 0 of a buffer opcode selects the buffer
`define FPCI_OP_MASK     8'hFE
`define FPCI_OP_BUF_WR   8'h10
`define FPCI_OP_BUF_RD   8'h20
`define FPCI_OP_PROG     8'h30
`define FPCI_OP_XFER     8'h40
`define FPCI_OP_CMP      8'h50
`define FPCI_OP_ERASE    8'h60
`define FPCI_OP_PROT_EN  8'h70
`define FPCI_OP_LOCK     8'h80
`define FPCI_OP_SEC_SET  8'h90

// frame layout: opcode, three address bytes, then data
`define FPCI_IDX_W       3
`define FPCI_IDX_DATA    3'h4
`define FPCI_IDX_A2      3'h1
`define FPCI_IDX_A1      3'h2
`define FPCI_IDX_A0      3'h3
`define FPCI_BIT_LAST    3'h7

// buffers and sectors
`define FPCI_BUF_AW      4
`define FPCI_BUF_DEPTH   16
`define FPCI_SEC_LSB     21
`define FPCI_SEC_W       3
`define FPCI_NSEC        8
`define FPCI_SEC_FLAG_B  23

// self-timed operation length
`define FPCI_CLK_MHZ     100
`define FPCI_OP_NS       2000
`define FPCI_OP_CYC      ((`FPCI_OP_NS * `FPCI_CLK_MHZ + 999) / 1000)
`define FPCI_TMR_W       12

`endif

//--- hdl/fpci_pkg.sv
// types for the flash pin control interface
package fpci_pkg;

	typedef logic [7:0] fpci_byte_t;

	typedef enum logic {
		ST_IDLE,
		ST_BUSY
	} fpci_state_t;

	typedef enum logic [2:0] {
		CMD_OTHER,
		CMD_PROG,
		CMD_ERASE,
		CMD_SELF,
		CMD_PROT_EN,
		CMD_LOCK,
		CMD_SEC_SET
	} fpci_cmd_t;

endpackage : fpci_pkg

//--- hdl/fpci_sync.sv
// two-flop level synchroniser
`timescale 1ns/1ps
module fpci_sync (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic d_i,
	output logic      q_o
);
	logic meta_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= 1'b0;
			q_o    <= 1'b0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule : fpci_sync

//--- hdl/fpci_top.sv
// flash pin control: link sampling, protection and busy sequencing
`timescale 1ns/1ps
`include "fpci_cfg.svh"

// Summary of operation
// - command, address and write data sampled on rising link clock edge.
// - read data changes only on falling link clock edge.
// - byte mode: eight shared lines, host drives input, device drives output.
// - write-protect low guards flagged sectors regardless of software enable.
// - guarded program or erase does nothing; idle after chip select rises.
// - protection-enable and lockdown commands still work with protect low.
// - reset low aborts operation and returns control machine to idle.
// - device stays in reset while reset low, resumes when high.
// - no internal power-on reset; core reset comes only from the reset pin.
// - busy driven low throughout self-timed program, erase, compare, transfer.
// - busy pin is open drain, pulled low only while busy.
// - while busy refuse array and busy buffer, serve the other buffer.
// - chip select high floats serial and byte outputs and ignores link inputs; busy pin unaffected.
// - port select picks serial or byte port; the other floats, ignored.
// - chip select rising mid-operation lets the operation finish.
module fpci_top (
	input  wire logic              clk_i,
	input  wire logic              rstn_i,
	input  wire logic              ce_i,
	input  wire logic              sck_i,
	input  wire logic              cs_n_i,
	input  wire logic              port_select_i,
	input  wire logic              si_i,
	output logic                   so_o,
	output logic                   so_oe_n_o,
	input  wire fpci_pkg::fpci_byte_t parallel_lines_i,
	output fpci_pkg::fpci_byte_t   parallel_lines_o,
	output logic                   parallel_lines_oe_n_o,
	input  wire logic              wp_n_i,
	output logic                   rdy_o,
	output logic                   rdy_oe_n_o
);
	import fpci_pkg::*;

	// link domain
	// frame logic is cleared by the frame's own chip select, so no
	// link clock edge is needed outside a frame
	logic link_rst;
	assign link_rst = cs_n_i | ~rstn_i;

	logic [2:0]              bit_q;
	logic [`FPCI_IDX_W-1:0]  idx_q;
	fpci_byte_t              shift_q;
	fpci_byte_t              op_q;
	logic [23:0]             addr_q;
	logic [`FPCI_BUF_AW-1:0] ptr_q;
	fpci_byte_t              rd_byte_q;

	fpci_byte_t              in_byte;
	logic                    byte_end;
	logic                    buf_sel;
	logic                    data_phase;
	logic                    is_rd;
	logic                    is_wr;
	logic                    buf_ok;

	logic                    busy_l;
	logic                    bvld_l;
	logic                    bbuf_l;

	// port select chooses which lines are heard at all
	always_comb begin
		if (port_select_i) begin
			in_byte  = {shift_q[6:0], si_i};
			byte_end = (bit_q == `FPCI_BIT_LAST);
		end else begin
			in_byte  = parallel_lines_i;
			byte_end = 1'b1;
		end
	end

	assign buf_sel    = op_q[0];
	assign data_phase = (idx_q == `FPCI_IDX_DATA);
	assign is_rd      = ((op_q & `FPCI_OP_MASK) == `FPCI_OP_BUF_RD);
	assign is_wr      = ((op_q & `FPCI_OP_MASK) == `FPCI_OP_BUF_WR);
	assign buf_ok     = !(busy_l && bvld_l && (bbuf_l == buf_sel));

	// bit and byte assembly on the rising edge
	always_ff @(posedge sck_i or posedge link_rst) begin
		if (link_rst) begin
			bit_q   <= '0;
			idx_q   <= '0;
			shift_q <= '0;
		end else begin
			shift_q <= in_byte;
			if (port_select_i) begin
				bit_q <= bit_q + 1'b1;
			end else begin
				bit_q <= '0;
			end
			if (byte_end && !data_phase) begin
				idx_q <= idx_q + 1'b1;
			end
		end
	end

	// opcode and address latch
	always_ff @(posedge sck_i or posedge link_rst) begin
		if (link_rst) begin
			op_q <= '0;
		end else if (byte_end && idx_q == '0) begin
			op_q <= in_byte;
		end
	end

	always_ff @(posedge sck_i or negedge rstn_i) begin
		if (!rstn_i) begin
			addr_q <= '0;
		end else if (byte_end && !cs_n_i) begin
			case (idx_q)
				`FPCI_IDX_A2: addr_q[23:16] <= in_byte;
				`FPCI_IDX_A1: addr_q[15:8]  <= in_byte;
				`FPCI_IDX_A0: addr_q[7:0]   <= in_byte;
				default:      addr_q        <= addr_q;
			endcase
		end
	end

	// command hand-off: the opcode stays put until chip select rises and the
	// address until the next frame's address bytes, after the core has copied them
	logic cmd_tgl_q;

	always_ff @(posedge sck_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cmd_tgl_q <= 1'b0;
		end else if (!cs_n_i && byte_end && idx_q == `FPCI_IDX_A0) begin
			cmd_tgl_q <= ~cmd_tgl_q;
		end
	end

	// buffer memories live on the link clock only
	fpci_byte_t buf_mem [2][`FPCI_BUF_DEPTH];

	always_ff @(posedge sck_i) begin
		if (!link_rst && is_wr && data_phase && byte_end && buf_ok) begin
			buf_mem[buf_sel][ptr_q] <= in_byte;
		end
	end

	// buffer pointer and read byte, refreshed as the last address byte and each data byte close
	always_ff @(posedge sck_i or posedge link_rst) begin
		if (link_rst) begin
			ptr_q     <= '0;
			rd_byte_q <= '0;
		end else if (byte_end) begin
			if (idx_q == `FPCI_IDX_A0) begin
				ptr_q <= in_byte[`FPCI_BUF_AW-1:0];
				if (buf_ok) begin
					rd_byte_q <=
						buf_mem[buf_sel][in_byte[`FPCI_BUF_AW-1:0]];
				end else begin
					rd_byte_q <= '0;
				end
			end else if (data_phase) begin
				ptr_q <= ptr_q + 1'b1;
				if (buf_ok) begin
					rd_byte_q <= buf_mem[buf_sel][ptr_q + 1'b1];
				end else begin
					rd_byte_q <= '0;
				end
			end
		end
	end

	// output drive on the falling edge; enables are active low
	always_ff @(negedge sck_i or posedge link_rst) begin
		if (link_rst) begin
			so_o                  <= 1'b0;
			so_oe_n_o             <= 1'b1;
			parallel_lines_o      <= '0;
			parallel_lines_oe_n_o <= 1'b1;
		end else if (is_rd && data_phase) begin
			if (port_select_i) begin
				so_o                  <= rd_byte_q[3'h7 - bit_q];
				so_oe_n_o             <= 1'b0;
				parallel_lines_oe_n_o <= 1'b1;
			end else begin
				parallel_lines_o      <= rd_byte_q;
				parallel_lines_oe_n_o <= 1'b0;
				so_oe_n_o             <= 1'b1;
			end
		end else begin
			so_oe_n_o             <= 1'b1;
			parallel_lines_oe_n_o <= 1'b1;
		end
	end

	// core status into the link domain; stale for the first two
	// edges of a frame, which fall well before any data byte
	logic busy_q;
	logic bvld_q;
	logic bbuf_q;

	fpci_sync u_sync_busy (
		.clk_i   (sck_i),
		.rst_n_i (rstn_i),
		.d_i     (busy_q),
		.q_o     (busy_l)
	);

	fpci_sync u_sync_bvld (
		.clk_i   (sck_i),
		.rst_n_i (rstn_i),
		.d_i     (bvld_q),
		.q_o     (bvld_l)
	);

	fpci_sync u_sync_bbuf (
		.clk_i   (sck_i),
		.rst_n_i (rstn_i),
		.d_i     (bbuf_q),
		.q_o     (bbuf_l)
	);

	// core domain
	// reset synchroniser; its only reset source is the reset pin, with no power-on reset
	logic rst_n;

	fpci_sync u_sync_rst (
		.clk_i   (clk_i),
		.rst_n_i (rstn_i),
		.d_i     (1'b1),
		.q_o     (rst_n)
	);

	logic cs_s;
	logic tgl_s;
	logic wp_s;

	fpci_sync u_sync_cs (
		.clk_i   (clk_i),
		.rst_n_i (rst_n),
		.d_i     (~cs_n_i),
		.q_o     (cs_s)
	);

	fpci_sync u_sync_tgl (
		.clk_i   (clk_i),
		.rst_n_i (rst_n),
		.d_i     (cmd_tgl_q),
		.q_o     (tgl_s)
	);

	fpci_sync u_sync_wp (
		.clk_i   (clk_i),
		.rst_n_i (rst_n),
		.d_i     (~wp_n_i),
		.q_o     (wp_s)
	);

	logic                   cs_prev_q;
	logic                   tgl_prev_q;
	logic                   pend_q;
	fpci_byte_t             c_op_q;
	logic [23:0]            c_addr_q;
	fpci_state_t            state_q;
	logic [`FPCI_NSEC-1:0]  map_q;
	logic [`FPCI_NSEC-1:0]  lock_q;
	logic                   sw_en_q;

	logic                   tgl_edge;
	logic                   frame_end;
	logic                   exec;
	logic                   start;
	logic                   done;
	fpci_cmd_t              cmd;
	logic [`FPCI_SEC_W-1:0] sec;
	logic                   guarded;

	assign tgl_edge  = tgl_s ^ tgl_prev_q;
	assign frame_end = cs_prev_q && !cs_s;
	assign exec      = pend_q && frame_end;
	assign sec       = c_addr_q[`FPCI_SEC_LSB +: `FPCI_SEC_W];
	// hardware guard ignores the software enable
	assign guarded   = lock_q[sec] ||
		(map_q[sec] && (sw_en_q || wp_s));

	always_comb begin
		case (c_op_q & `FPCI_OP_MASK)
			`FPCI_OP_PROG:    cmd = CMD_PROG;
			`FPCI_OP_ERASE:   cmd = CMD_ERASE;
			`FPCI_OP_XFER:    cmd = CMD_SELF;
			`FPCI_OP_CMP:     cmd = CMD_SELF;
			`FPCI_OP_PROT_EN: cmd = CMD_PROT_EN;
			`FPCI_OP_LOCK:    cmd = CMD_LOCK;
			`FPCI_OP_SEC_SET: cmd = CMD_SEC_SET;
			default:          cmd = CMD_OTHER;
		endcase
	end

	// array refused while busy; guarded writes simply vanish
	always_comb begin
		start = 1'b0;
		if (exec && state_q == ST_IDLE) begin
			case (cmd)
				CMD_PROG:  start = !guarded;
				CMD_ERASE: start = !guarded;
				CMD_SELF:  start = 1'b1;
				default:   start = 1'b0;
			endcase
		end
	end

	// edge trackers and command copy
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cs_prev_q  <= 1'b0;
			tgl_prev_q <= 1'b0;
			pend_q     <= 1'b0;
			c_op_q     <= '0;
			c_addr_q   <= '0;
		end else if (ce_i) begin
			cs_prev_q  <= cs_s;
			tgl_prev_q <= tgl_s;
			// a new capture wins over the consume
			pend_q     <= tgl_edge | (pend_q & ~frame_end);
			if (tgl_edge) begin
				c_op_q   <= op_q;
				c_addr_q <= addr_q;
			end
		end
	end

	// protection state; usable whatever the protect pin shows
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			map_q   <= '0;
			lock_q  <= '0;
			sw_en_q <= 1'b0;
		end else if (ce_i && exec) begin
			case (cmd)
				CMD_PROT_EN: sw_en_q     <= 1'b1;
				CMD_LOCK:    lock_q[sec] <= 1'b1;
				CMD_SEC_SET: begin
					if (!lock_q[sec]) begin
						map_q[sec] <= c_addr_q[`FPCI_SEC_FLAG_B];
					end
				end
				default: sw_en_q <= sw_en_q;
			endcase
		end
	end

	// control machine; chip select has no say once busy
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			bvld_q  <= 1'b0;
			bbuf_q  <= 1'b0;
		end else if (ce_i) begin
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						state_q <= ST_BUSY;
						bvld_q  <= (cmd != CMD_ERASE);
						bbuf_q  <= c_op_q[0];
					end
				end
				ST_BUSY: begin
					if (done) begin
						state_q <= ST_IDLE;
						bvld_q  <= 1'b0;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	fpci_busy_timer u_timer (
		.clk_i   (clk_i),
		.rst_n_i (rst_n),
		.ce_i    (ce_i),
		.start_i (start),
		.done_o  (done)
	);

	// open-drain busy: the driven level is always low
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			busy_q     <= 1'b0;
			rdy_o      <= 1'b0;
			rdy_oe_n_o <= 1'b1;
		end else if (ce_i) begin
			busy_q     <= start || (state_q == ST_BUSY && !done);
			rdy_o      <= 1'b0;
			rdy_oe_n_o <= !(start || (state_q == ST_BUSY && !done));
		end
	end

endmodule : fpci_top

//--- testbench/fpci_host.sv
// host model driving link frames
`timescale 1ns/1ps
module fpci_host (
	output logic                      sck_o,
	output logic                      cs_n_o,
	output logic                      port_select_o,
	output logic                      si_o,
	output fpci_pkg::fpci_byte_t      lines_o,
	input  wire logic                 so_i,
	input  wire fpci_pkg::fpci_byte_t lines_i
);
	import fpci_pkg::*;
	logic       drv_q;
	fpci_byte_t out_q;
	// released lines toggle so stale data never reads as valid
	assign lines_o = drv_q ? out_q : (8'h5A ^ {8{sck_o}});
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		port_select_o = 1'b1;
		si_o = 1'b0;
		drv_q = 1'b0;
		out_q = 8'h00;
	end
	task automatic begin_frame(input logic ser);
		#3 port_select_o = ser;
		#20 cs_n_o = 1'b0;
		#80;
	endtask : begin_frame
	task automatic xfer(input fpci_byte_t wr, input logic drv,
			output fpci_byte_t rd);
		rd = 8'h00;
		if (port_select_o) begin
			for (int i = 7; i >= 0; i--) begin
				si_o = wr[i];
				// sample just before the rising edge, after the falling launch
				#80 rd[i] = so_i;
				sck_o = 1'b1;
				#80 sck_o = 1'b0;
			end
		end else begin
			drv_q = drv;
			out_q = wr;
			si_o = ~si_o;
			#80 rd = lines_i;
			sck_o = 1'b1;
			#80 sck_o = 1'b0;
		end
	endtask : xfer
	task automatic end_frame();
		#40 drv_q = 1'b0;
		cs_n_o = 1'b1;
		#40;
	endtask : end_frame
endmodule : fpci_host

//--- testbench/fpci_top_props.sv
// checker on the flash pin control top ports
`timescale 1ns/1ps
module fpci_top_props (
	input wire logic                 clk_i,
	input wire logic                 rstn_i,
	input wire logic                 sck_i,
	input wire logic                 cs_n_i,
	input wire logic                 port_select_i,
	input wire logic                 so_o,
	input wire logic                 so_oe_n_o,
	input wire fpci_pkg::fpci_byte_t parallel_lines_o,
	input wire logic                 parallel_lines_oe_n_o,
	input wire logic                 rdy_o,
	input wire logic                 rdy_oe_n_o
);
	import fpci_pkg::*;
	logic [8:0] busy_cnt_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// low cycles of busy; valid only while ce_i stays high
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			busy_cnt_q <= 9'h000;
		else if (rdy_oe_n_o)
			busy_cnt_q <= 9'h000;
		else
			busy_cnt_q <= busy_cnt_q + 9'h001;
	end
	property p_cs_float;
		cs_n_i |-> so_oe_n_o && parallel_lines_oe_n_o;
	endproperty
	a_cs_float: assert property (p_cs_float)
		else $error("output driven while deselected");
	property p_ser_float;
		port_select_i |-> parallel_lines_oe_n_o;
	endproperty
	a_ser_float: assert property (p_ser_float)
		else $error("byte port driven in serial mode");
	property p_byte_float;
		!port_select_i |-> so_oe_n_o;
	endproperty
	a_byte_float: assert property (p_byte_float)
		else $error("serial out driven in byte mode");
	property p_rst_float;
		$rose(rstn_i) |-> so_oe_n_o && parallel_lines_oe_n_o && rdy_oe_n_o;
	endproperty
	a_rst_float: assert property (p_rst_float)
		else $error("pin driven out of reset");
	property p_od_low;
		rdy_o == 1'b0;
	endproperty
	a_od_low: assert property (p_od_low)
		else $error("busy pin drives high");
	property p_busy_len;
		$rose(rdy_oe_n_o) |-> busy_cnt_q inside {[200:201]};
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("busy length wrong");
	property p_busy_max;
		!rdy_oe_n_o |-> busy_cnt_q < 9'h0CA;
	endproperty
	a_busy_max: assert property (p_busy_max)
		else $error("busy overran");
	property p_busy_after_cs;
		$fell(rdy_oe_n_o) |-> cs_n_i && $past(cs_n_i, 3);
	endproperty
	a_busy_after_cs: assert property (p_busy_after_cs)
		else $error("busy began inside a frame");
	property p_so_edge;
		$changed(so_o) |-> $fell(sck_i) || $rose(cs_n_i);
	endproperty
	a_so_edge: assert property (p_so_edge)
		else $error("serial out moved off falling edge");
	property p_lines_edge;
		$changed(parallel_lines_o) |-> $fell(sck_i) || $rose(cs_n_i);
	endproperty
	a_lines_edge: assert property (p_lines_edge)
		else $error("byte out moved off falling edge");
	c_busy: cover property ($rose(rdy_oe_n_o));
	c_ser_rd: cover property ($fell(so_oe_n_o));
	c_byte_rd: cover property ($fell(parallel_lines_oe_n_o));
endmodule : fpci_top_props

bind fpci_top fpci_top_props u_props (.clk_i(clk_i), .rstn_i(rstn_i),
	.sck_i(sck_i), .cs_n_i(cs_n_i), .port_select_i(port_select_i),
	.so_o(so_o), .so_oe_n_o(so_oe_n_o), .parallel_lines_o(parallel_lines_o),
	.parallel_lines_oe_n_o(parallel_lines_oe_n_o), .rdy_o(rdy_o),
	.rdy_oe_n_o(rdy_oe_n_o));

//--- testbench/fpci_top_tb.sv
// testbench for the flash pin control top
`timescale 1ns/1ps
module fpci_top_tb;
	import fpci_pkg::*;
	logic       clk_i, rstn_i, ce_i, wp_n_i;
	logic       sck, cs_n, psel, si, so, so_w, so_oe_n, lines_oe_n;
	logic       rdy, rdy_oe_n;
	fpci_byte_t host_lines, dut_lines, lines_w, rd;
	int         error_cnt, total_checks;
	assign lines_w = lines_oe_n ? host_lines : dut_lines;
	assign so_w = so_oe_n ? ~sck : so;
	fpci_host host_u (.sck_o(sck), .cs_n_o(cs_n), .port_select_o(psel),
		.si_o(si), .lines_o(host_lines), .so_i(so_w), .lines_i(lines_w));
	fpci_top dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
		.sck_i(sck), .cs_n_i(cs_n), .port_select_i(psel), .si_i(si),
		.so_o(so), .so_oe_n_o(so_oe_n), .parallel_lines_i(lines_w),
		.parallel_lines_o(dut_lines), .parallel_lines_oe_n_o(lines_oe_n),
		.wp_n_i(wp_n_i), .rdy_o(rdy), .rdy_oe_n_o(rdy_oe_n));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude
	task automatic chk(input string n, input fpci_byte_t e,
			input fpci_byte_t g);
		total_checks++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", n, e, g);
			error_cnt++;
		end
	endtask : chk
	task automatic chk_bit(input string n, input logic e, input logic g);
		chk(n, {7'h00, e}, {7'h00, g});
	endtask : chk_bit
	task automatic tick();
		@(posedge clk_i);
		#1;
	endtask : tick
	task automatic cmd(input logic ser, input fpci_byte_t c,
			input logic [23:0] a);
		@(posedge clk_i);
		host_u.begin_frame(ser);
		host_u.xfer(c, 1'b1, rd);
		host_u.xfer(a[23:16], 1'b1, rd);
		host_u.xfer(a[15:8], 1'b1, rd);
		host_u.xfer(a[7:0], 1'b1, rd);
	endtask : cmd
	task automatic op(input fpci_byte_t c, input logic [23:0] a);
		cmd(1'b0, c, a);
		host_u.end_frame();
	endtask : op
	task automatic put(input fpci_byte_t d);
		host_u.xfer(d, 1'b1, rd);
	endtask : put
	task automatic get(input fpci_byte_t e);
		host_u.xfer(8'h00, 1'b0, rd);
		chk("read_data", e, rd);
	endtask : get
	task automatic wait_busy(input logic e);
		for (int n = 0; n < 20 && rdy_oe_n !== 1'b0; n++)
			tick();
		chk_bit("busy_n", ~e, rdy_oe_n);
	endtask : wait_busy
	task automatic wait_ready();
		int n;
		for (n = 0; n < 300 && rdy_oe_n !== 1'b1; n++)
			tick();
		if (n == 300) begin
			$display("Error busy_end expected 1 seen timeout");
			error_cnt++;
			conclude();
		end
	endtask : wait_ready
	task automatic s_serial();
		cmd(1'b1, 8'h10, 24'h00_0003);
		put(8'hA5);
		put(8'h3C);
		host_u.end_frame();
		cmd(1'b1, 8'h20, 24'h00_0003);
		get(8'hA5);
		get(8'h3C);
		host_u.end_frame();
		chk_bit("so_oe_n", 1'b1, so_oe_n);
	endtask : s_serial
	task automatic s_byte();
		cmd(1'b0, 8'h11, 24'h00_000F);
		put(8'h69);
		put(8'h96);
		host_u.end_frame();
		cmd(1'b0, 8'h21, 24'h00_000F);
		get(8'h69);
		get(8'h96);
		host_u.end_frame();
	endtask : s_byte
	task automatic s_busy();
		op(8'h30, 24'h00_0000);
		wait_busy(1'b1);
		cmd(1'b0, 8'h21, 24'h00_000F);
		get(8'h69);
		host_u.end_frame();
		cmd(1'b0, 8'h20, 24'h00_0003);
		get(8'h00);
		host_u.end_frame();
		chk_bit("busy_held", 1'b0, rdy_oe_n);
		wait_ready();
	endtask : s_busy
	task automatic s_guard();
		op(8'h90, 24'h80_0000);
		@(posedge clk_i) wp_n_i <= 1'b0;
		repeat (4) tick();
		op(8'h30, 24'h80_0000);
		wait_busy(1'b0);
		op(8'h60, 24'h80_0000);
		wait_busy(1'b0);
		op(8'h30, 24'h00_0000);
		wait_busy(1'b1);
		wait_ready();
		op(8'h70, 24'h00_0000);
		op(8'h80, 24'hA0_0000);
		@(posedge clk_i) wp_n_i <= 1'b1;
		repeat (4) tick();
		op(8'h30, 24'h80_0000);
		wait_busy(1'b0);
		op(8'h30, 24'hA0_0000);
		wait_busy(1'b0);
	endtask : s_guard
	task automatic s_reset();
		fpci_byte_t ops [3] = '{8'h40, 8'h50, 8'h60};
		op(8'h31, 24'h00_0000);
		wait_busy(1'b1);
		@(posedge clk_i) rstn_i <= 1'b0;
		tick();
		chk_bit("abort", 1'b1, rdy_oe_n);
		repeat (3) tick();
		@(posedge clk_i) rstn_i <= 1'b1;
		repeat (10) tick();
		chk_bit("idle", 1'b1, rdy_oe_n);
		foreach (ops[i]) begin
			op(ops[i], 24'h00_0000);
			wait_busy(1'b1);
			wait_ready();
		end
	endtask : s_reset
	initial begin
		rstn_i = 1'b0;
		ce_i = 1'b1;
		wp_n_i = 1'b1;
		error_cnt = 0;
		total_checks = 0;
		repeat (10) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		s_serial();
		s_byte();
		s_busy();
		s_guard();
		s_reset();
		conclude();
	end
endmodule : fpci_top_tb
